// file: design/brf_defines.svh
/*
 Constants for the banked register file: mode codes, status word fields,
 physical entry indices and reset values.
 Assumes inclusion by bare name from any design file.
*/
`ifndef BRF_DEFINES_SVH
`define BRF_DEFINES_SVH

`define BRF_MODE_USR      5'h10
`define BRF_MODE_FIQ      5'h11
`define BRF_MODE_IRQ      5'h12
`define BRF_MODE_SVC      5'h13
`define BRF_MODE_ABT      5'h17
`define BRF_MODE_UND      5'h1B
`define BRF_MODE_SYS      5'h1F

`define BRF_PSR_N         31
`define BRF_PSR_Z         30
`define BRF_PSR_C         29
`define BRF_PSR_V         28
`define BRF_PSR_FLAGS_HI  31
`define BRF_PSR_FLAGS_LO  28
`define BRF_PSR_CTRL_HI   7
`define BRF_PSR_CTRL_LO   0
`define BRF_PSR_I         7
`define BRF_PSR_F         6
`define BRF_PSR_MODE_HI   4
`define BRF_PSR_MODE_LO   0

`define BRF_NUM_GPR       30
`define BRF_NUM_SAVED     5
`define BRF_IDX_FIQ_LO    4'h8
`define BRF_IDX_STACK     4'hD
`define BRF_IDX_LINK      4'hE
`define BRF_IDX_PC        4'hF
`define BRF_PHY_FIQ_BASE  5'h0F
`define BRF_PHY_STACK_BASE 5'h14
`define BRF_PHY_LINK_BASE 5'h19
`define BRF_PC_READ_AHEAD 32'h0000_0008

`define BRF_STATUS_RESET  32'h0000_00D3
`define BRF_PC_RESET      30'h0000_0000
`define BRF_WORD_ZERO     32'h0000_0000
`define BRF_PRIV_RESET    1'b1
`define BRF_VALID_RESET   1'b1

`endif

// file: design/brf_pkg.sv
/*
 Types shared by the banked register file.
 Assumes brf_defines.svh is compiled alongside.
*/
package brf_pkg;

	typedef struct packed {
		logic        en;
		logic [3:0]  idx;
		logic [31:0] data;
	} brf_wr_t;

	typedef struct packed {
		logic        n;
		logic        z;
		logic        c;
		logic        v;
	} brf_flags_t;

	typedef struct packed {
		logic        valid;
		logic [4:0]  bank;
		logic        priv;
		logic        has_saved;
		logic [2:0]  saved_sel;
		logic [1:0]  sp_lr_sel;
	} brf_mode_info_t;

	typedef enum logic [2:0] {
		BRF_BANK_USR = 3'h0,
		BRF_BANK_SVC = 3'h1,
		BRF_BANK_ABT = 3'h2,
		BRF_BANK_UND = 3'h3,
		BRF_BANK_IRQ = 3'h4,
		BRF_BANK_FIQ = 3'h5
	} brf_bank_t;

endpackage

// file: design/brf_mode_decode.sv
/*
 Mode decoder: maps the 5-bit mode field to bank selection, privilege and
 saved-status ownership.
 Assumes a purely combinational use inside the register file.
*/
`timescale 1ns/1ps
`include "brf_defines.svh"

module brf_mode_decode
(
	input  wire logic [4:0]  mode_i,
	output brf_pkg::brf_bank_t bank_o,
	output logic             valid_o,
	output logic             priv_o,
	output logic             has_saved_o,
	output logic [2:0]       saved_sel_o
);

	always_comb
	begin
		bank_o      = brf_pkg::BRF_BANK_USR;
		valid_o     = 1'b1;
		priv_o      = 1'b1;
		has_saved_o = 1'b1;
		saved_sel_o = 3'h0;
		case (mode_i) // [RULE_14] [RULE_16]
			`BRF_MODE_USR:
			begin
				priv_o      = 1'b0; // [RULE_15]
				has_saved_o = 1'b0;
			end
			`BRF_MODE_SYS:
			begin
				has_saved_o = 1'b0; // [RULE_04] [RULE_05]
			end
			`BRF_MODE_SVC:
			begin
				bank_o      = brf_pkg::BRF_BANK_SVC;
				saved_sel_o = 3'h0;
			end
			`BRF_MODE_ABT:
			begin
				bank_o      = brf_pkg::BRF_BANK_ABT;
				saved_sel_o = 3'h1;
			end
			`BRF_MODE_UND:
			begin
				bank_o      = brf_pkg::BRF_BANK_UND;
				saved_sel_o = 3'h2;
			end
			`BRF_MODE_IRQ:
			begin
				bank_o      = brf_pkg::BRF_BANK_IRQ;
				saved_sel_o = 3'h3;
			end
			`BRF_MODE_FIQ:
			begin
				bank_o      = brf_pkg::BRF_BANK_FIQ;
				saved_sel_o = 3'h4;
			end
			default:
			begin
				valid_o     = 1'b0; // [RULE_19]
				priv_o      = 1'b0;
				has_saved_o = 1'b0;
			end
		endcase
	end

endmodule

// file: design/brf_regfile.sv
/*
 Mode-banked register file: 30 general entries, current and five saved status
 words, program counter. Two registered read ports, one write port, exception
 entry, condition flag update, subroutine link write and status transfers.
 Assumes the decode/execute logic on the same clock drives all requests as
 synchronous single-cycle strobes.
*/
`timescale 1ns/1ps
`include "brf_defines.svh"

// Functional notes
// [RULE_01] 37 entries: 30 general, 6 status, PC
// [RULE_02] expose indices 0-14, PC, status per mode
// [RULE_03] general entries hold full 32-bit words
// [RULE_04] stack slot banked per mode, system shares user
// [RULE_05] link slot banked, exception return address here
// [RULE_06] call branch writes return address to link
// [RULE_07] fast interrupt banks indices 8 to 12
// [RULE_08] counter slot reads with low bits zero
// [RULE_09] counter slot write drops low two bits
// [RULE_10] counter slot read gives PC plus 8
// [RULE_11] current status always; saved copied on exception
// [RULE_12] status holds flags, interrupt disables, mode
// [RULE_13] flags updated from results, exported for conditions
// [RULE_14] seven modes select visible banked entries
// [RULE_15] user unprivileged, others privileged
// [RULE_16] mode codes decode per fixed table
// [RULE_17] no saved status in user/system modes
// [RULE_18] control byte writable only when privileged
// [RULE_19] undefined mode code falls back to user bank
module brf_regfile
(
	input  wire logic                clk_i,
	input  wire logic                reset_n_i,
	input  wire logic [3:0]          rd_a_idx_i,
	input  wire logic [3:0]          rd_b_idx_i,
	input  wire brf_pkg::brf_wr_t    wr_i,
	input  wire logic                call_branch_i,
	input  wire logic [31:0]         call_return_i,
	input  wire logic                pc_load_i,
	input  wire logic [31:0]         pc_value_i,
	input  wire logic                flags_we_i,
	input  wire brf_pkg::brf_flags_t flags_i,
	input  wire logic                status_we_i,
	input  wire logic                status_saved_sel_i,
	input  wire logic [31:0]         status_data_i,
	input  wire logic                exc_i,
	input  wire logic [4:0]          exc_mode_i,
	input  wire logic                exc_fiq_dis_i,
	input  wire logic [31:0]         exc_return_i,
	input  wire logic [31:0]         exc_vector_i,
	output logic [31:0]              rd_a_data_o,
	output logic [31:0]              rd_b_data_o,
	output logic [31:0]              pc_o,
	output logic [31:0]              current_status_word_o,
	output logic [31:0]              saved_status_word_o,
	output brf_pkg::brf_flags_t      flags_o,
	output logic [4:0]               mode_o,
	output logic                     privileged_o,
	output logic                     mode_valid_o
);

	//------------------------------------------------------------
	// storage
	//------------------------------------------------------------
	logic [31:0] gpr_r     [`BRF_NUM_GPR];   // [RULE_01] [RULE_03]
	logic [31:0] gpr_nxt   [`BRF_NUM_GPR];
	logic [31:0] saved_r   [`BRF_NUM_SAVED];
	logic [31:0] saved_nxt [`BRF_NUM_SAVED];
	logic [31:0] cur_r;
	logic [31:0] cur_nxt;
	logic [29:0] pc_r;
	logic [29:0] pc_nxt;
	logic [31:0] rd_a_r;
	logic [31:0] rd_a_nxt;
	logic [31:0] rd_b_r;
	logic [31:0] rd_b_nxt;
	logic [31:0] saved_out_r;
	logic [31:0] saved_out_nxt;
	logic        priv_out_r;
	logic        priv_out_nxt;
	logic        valid_out_r;
	logic        valid_out_nxt;

	brf_pkg::brf_bank_t bank;
	logic               priv;
	logic               has_saved;
	logic [2:0]         saved_sel;
	logic               nxt_valid;
	logic               nxt_priv;
	logic               nxt_has_saved;
	logic [2:0]         nxt_saved_sel;

	//------------------------------------------------------------
	// mode decode
	//------------------------------------------------------------
	brf_mode_decode u_mode
	(
		.mode_i      (cur_r[`BRF_PSR_MODE_HI:`BRF_PSR_MODE_LO]),
		.bank_o      (bank),
		.valid_o     (),
		.priv_o      (priv),
		.has_saved_o (has_saved),
		.saved_sel_o (saved_sel)
	);

	// decode of the mode being loaded at this edge
	brf_mode_decode u_mode_nxt
	(
		.mode_i      (cur_nxt[`BRF_PSR_MODE_HI:`BRF_PSR_MODE_LO]),
		.bank_o      (),
		.valid_o     (nxt_valid),
		.priv_o      (nxt_priv),
		.has_saved_o (nxt_has_saved),
		.saved_sel_o (nxt_saved_sel)
	);

	//------------------------------------------------------------
	// index to physical entry
	//------------------------------------------------------------
	function automatic logic [4:0] phys_idx(input logic [3:0] idx, input brf_pkg::brf_bank_t bk);
		logic [4:0] p;
		p = {1'b0, idx};
		if ((bk == brf_pkg::BRF_BANK_FIQ) && (idx >= `BRF_IDX_FIQ_LO) && (idx < `BRF_IDX_STACK))
			p = `BRF_PHY_FIQ_BASE + 5'(idx - `BRF_IDX_FIQ_LO); // [RULE_07]
		else if ((idx == `BRF_IDX_STACK) && (bk != brf_pkg::BRF_BANK_USR))
			p = `BRF_PHY_STACK_BASE + 5'(bk) - 5'h1; // [RULE_04]
		else if ((idx == `BRF_IDX_LINK) && (bk != brf_pkg::BRF_BANK_USR))
			p = `BRF_PHY_LINK_BASE + 5'(bk) - 5'h1; // [RULE_05]
		return p;
	endfunction

	function automatic logic [31:0] read_port(input logic [3:0] idx, input brf_pkg::brf_bank_t bk,
	                                          input logic [31:0] gv [`BRF_NUM_GPR], input logic [29:0] pcv);
		logic [31:0] r;
		if (idx == `BRF_IDX_PC)
			r = {pcv, 2'b00} + `BRF_PC_READ_AHEAD; // [RULE_08] [RULE_10]
		else
			r = gv[phys_idx(idx, bk)]; // [RULE_02]
		return r;
	endfunction

	//------------------------------------------------------------
	// next state
	//------------------------------------------------------------
	always_comb
	begin
		brf_pkg::brf_bank_t exc_bank;
		exc_bank = brf_pkg::BRF_BANK_SVC;
		case (exc_mode_i)
			`BRF_MODE_ABT: exc_bank = brf_pkg::BRF_BANK_ABT;
			`BRF_MODE_UND: exc_bank = brf_pkg::BRF_BANK_UND;
			`BRF_MODE_IRQ: exc_bank = brf_pkg::BRF_BANK_IRQ;
			`BRF_MODE_FIQ: exc_bank = brf_pkg::BRF_BANK_FIQ;
			default:       exc_bank = brf_pkg::BRF_BANK_SVC;
		endcase
		gpr_nxt   = gpr_r;
		saved_nxt = saved_r;
		cur_nxt   = cur_r;
		pc_nxt    = pc_r + 30'h1;
		if (pc_load_i)
			pc_nxt = pc_value_i[31:2];
		if (exc_i)
		begin
			gpr_nxt[`BRF_PHY_LINK_BASE + 5'(exc_bank) - 5'h1] = exc_return_i; // [RULE_05]
			saved_nxt[3'(exc_bank) - 3'h1] = cur_r; // [RULE_11]
			cur_nxt[`BRF_PSR_MODE_HI:`BRF_PSR_MODE_LO] = exc_mode_i; // [RULE_15] [RULE_18]
			cur_nxt[`BRF_PSR_I] = 1'b1;
			if (exc_fiq_dis_i)
				cur_nxt[`BRF_PSR_F] = 1'b1;
			pc_nxt = exc_vector_i[31:2];
		end
		else
		begin
			if (wr_i.en)
			begin
				if (wr_i.idx == `BRF_IDX_PC)
					pc_nxt = wr_i.data[31:2]; // [RULE_09]
				else
					gpr_nxt[phys_idx(wr_i.idx, bank)] = wr_i.data; // [RULE_03]
			end
			if (call_branch_i)
				gpr_nxt[phys_idx(`BRF_IDX_LINK, bank)] = call_return_i; // [RULE_06]
			if (status_we_i && !status_saved_sel_i)
			begin
				cur_nxt[31:`BRF_PSR_CTRL_HI + 1] = status_data_i[31:`BRF_PSR_CTRL_HI + 1]; // [RULE_11]
				if (priv)
					cur_nxt[`BRF_PSR_CTRL_HI:`BRF_PSR_CTRL_LO] =
						status_data_i[`BRF_PSR_CTRL_HI:`BRF_PSR_CTRL_LO]; // [RULE_18]
			end
			if (status_we_i && status_saved_sel_i && has_saved)
				saved_nxt[saved_sel] = status_data_i; // [RULE_17]
			if (flags_we_i)
				cur_nxt[`BRF_PSR_FLAGS_HI:`BRF_PSR_FLAGS_LO] = flags_i; // [RULE_13]
		end
		rd_a_nxt      = read_port(rd_a_idx_i, bank, gpr_r, pc_r);
		rd_b_nxt      = read_port(rd_b_idx_i, bank, gpr_r, pc_r);
	end

	// flopped mode outputs follow the state being loaded
	always_comb
	begin
		saved_out_nxt = nxt_has_saved ? saved_nxt[nxt_saved_sel] : `BRF_WORD_ZERO; // [RULE_17]
		priv_out_nxt  = nxt_priv; // [RULE_15]
		valid_out_nxt = nxt_valid; // [RULE_19]
	end

	//------------------------------------------------------------
	// registers
	//------------------------------------------------------------
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			for (int i = 0; i < `BRF_NUM_GPR; i++)
				gpr_r[i] <= `BRF_WORD_ZERO;
			for (int j = 0; j < `BRF_NUM_SAVED; j++)
				saved_r[j] <= `BRF_WORD_ZERO;
			cur_r       <= `BRF_STATUS_RESET; // [RULE_12]
			pc_r        <= `BRF_PC_RESET;
			rd_a_r      <= `BRF_WORD_ZERO;
			rd_b_r      <= `BRF_WORD_ZERO;
			saved_out_r <= `BRF_WORD_ZERO;
			priv_out_r  <= `BRF_PRIV_RESET;
			valid_out_r <= `BRF_VALID_RESET;
		end
		else
		begin
			gpr_r       <= gpr_nxt;
			saved_r     <= saved_nxt;
			cur_r       <= cur_nxt;
			pc_r        <= pc_nxt;
			rd_a_r      <= rd_a_nxt;
			rd_b_r      <= rd_b_nxt;
			saved_out_r <= saved_out_nxt;
			priv_out_r  <= priv_out_nxt;
			valid_out_r <= valid_out_nxt;
		end
	end

	//------------------------------------------------------------
	// outputs, all from flops
	//------------------------------------------------------------
	assign rd_a_data_o           = rd_a_r;
	assign rd_b_data_o           = rd_b_r;
	assign pc_o                  = {pc_r, 2'b00}; // [RULE_08]
	assign current_status_word_o = cur_r;
	assign saved_status_word_o   = saved_out_r;
	assign flags_o               = cur_r[`BRF_PSR_FLAGS_HI:`BRF_PSR_FLAGS_LO]; // [RULE_13]
	assign mode_o                = cur_r[`BRF_PSR_MODE_HI:`BRF_PSR_MODE_LO];
	assign privileged_o          = priv_out_r; // [RULE_15]
	assign mode_valid_o          = valid_out_r; // [RULE_19]

endmodule

// file: sim/brf_regfile_chk.sv
/*
 Port checker for the banked register file.
 Assumes binding onto brf_regfile with one clock and an active-low reset.
*/
`timescale 1ns/1ps
module brf_regfile_chk
(
	input wire logic                clk_i,
	input wire logic                reset_n_i,
	input wire logic [3:0]          rd_a_idx_i,
	input wire brf_pkg::brf_wr_t    wr_i,
	input wire logic                pc_load_i,
	input wire logic [31:0]         pc_value_i,
	input wire logic                flags_we_i,
	input wire brf_pkg::brf_flags_t flags_i,
	input wire logic                status_we_i,
	input wire logic                status_saved_sel_i,
	input wire logic                exc_i,
	input wire logic [4:0]          exc_mode_i,
	input wire logic [31:0]         exc_vector_i,
	input wire logic [31:0]         rd_a_data_o,
	input wire logic [31:0]         pc_o,
	input wire logic [31:0]         current_status_word_o,
	input wire logic [31:0]         saved_status_word_o,
	input wire brf_pkg::brf_flags_t flags_o,
	input wire logic [4:0]          mode_o,
	input wire logic                privileged_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	logic pc_wr;
	assign pc_wr = wr_i.en && (wr_i.idx == 4'hF) && !exc_i;

	a_pc_step: assert property (!pc_load_i && !exc_i && !pc_wr |=> pc_o == $past(pc_o) + 32'h4)
		else $error("pc step");
	a_pc_write: assert property (pc_wr |=> pc_o == ($past(wr_i.data) & 32'hFFFFFFFC))
		else $error("pc write");
	a_pc_load: assert property (pc_load_i && !exc_i && !pc_wr |=> pc_o == ($past(pc_value_i) & 32'hFFFFFFFC))
		else $error("pc load");
	a_pc_read: assert property (rd_a_idx_i == 4'hF |=> rd_a_data_o == $past(pc_o) + 32'h8)
		else $error("pc read");
	a_exc_entry: assert property (exc_i |=> pc_o == ($past(exc_vector_i) & 32'hFFFFFFFC)
		&& current_status_word_o[7] && saved_status_word_o == $past(current_status_word_o)) else $error("exc entry");
	a_exc_mode: assert property (exc_i && exc_mode_i inside {5'h11, 5'h12, 5'h13, 5'h17, 5'h1B}
		|=> mode_o == $past(exc_mode_i)) else $error("exc mode");
	a_flags_upd: assert property (flags_we_i && !exc_i |=> flags_o == $past(flags_i)
		&& current_status_word_o[31:28] == $past(flags_i)) else $error("flags");
	a_ctrl_guard: assert property (status_we_i && !status_saved_sel_i && !exc_i && mode_o == 5'h10
		|=> $stable(current_status_word_o[7:0])) else $error("control byte");
	a_saved_none: assert property (mode_o inside {5'h10, 5'h1F} |-> saved_status_word_o == 32'h0)
		else $error("saved word");
	a_user_unpriv: assert property (mode_o == 5'h10 |-> !privileged_o)
		else $error("user privilege");
endmodule

bind brf_regfile brf_regfile_chk chk_u
(
	.clk_i, .reset_n_i, .rd_a_idx_i, .wr_i, .pc_load_i, .pc_value_i, .flags_we_i, .flags_i,
	.status_we_i, .status_saved_sel_i, .exc_i, .exc_mode_i, .exc_vector_i, .rd_a_data_o,
	.pc_o, .current_status_word_o, .saved_status_word_o, .flags_o, .mode_o, .privileged_o
);

// file: sim/brf_exec_model.sv
/*
 Decode/execute stand-in driving every request of the register file.
 Assumes the bench calls one task at a time, after reset.
*/
`timescale 1ns/1ps
module brf_exec_model
(
	input  wire logic          clk_i,
	input  wire logic [31:0]   rd_a_i,
	input  wire logic [31:0]   rd_b_i,
	output brf_pkg::brf_wr_t   wr_o,
	output logic [3:0]         ra_o,
	output logic [3:0]         rb_o,
	output logic               call_o,
	output logic               pld_o,
	output logic               fwe_o,
	output brf_pkg::brf_flags_t flg_o,
	output logic               swe_o,
	output logic               ssel_o,
	output logic [31:0]        arg_o,
	output logic               exc_o,
	output logic [4:0]         emode_o,
	output logic               efd_o,
	output logic [31:0]        evec_o
);
	initial
		{wr_o, ra_o, rb_o, call_o, pld_o, fwe_o, flg_o, swe_o, ssel_o, arg_o, exc_o, emode_o, efd_o, evec_o} = '0;
	// one-cycle strobes, dropped at the next falling edge
	task automatic fin();
		@(negedge clk_i);
		{wr_o.en, call_o, pld_o, fwe_o, swe_o, exc_o} <= '0;
	endtask
	task automatic wr(input logic [3:0] i, input logic [31:0] d);
		@(negedge clk_i);
		wr_o <= {1'b1, i, d};
		fin();
	endtask
	task automatic sts(input logic s, input logic [31:0] d);
		@(negedge clk_i);
		{swe_o, ssel_o, arg_o} <= {1'b1, s, d};
		fin();
	endtask
	task automatic flg(input brf_pkg::brf_flags_t f);
		@(negedge clk_i);
		{fwe_o, flg_o} <= {1'b1, f};
		fin();
	endtask
	task automatic pcld(input logic [31:0] d);
		@(negedge clk_i);
		{pld_o, arg_o} <= {1'b1, d};
		fin();
	endtask
	task automatic call(input logic [31:0] d);
		@(negedge clk_i);
		{call_o, arg_o} <= {1'b1, d};
		fin();
	endtask
	task automatic exc(input logic [4:0] m, input logic f, input logic [31:0] r, input logic [31:0] v);
		@(negedge clk_i);
		{exc_o, emode_o, efd_o, arg_o, evec_o} <= {1'b1, m, f, r, v};
		fin();
	endtask
	task automatic rd(input logic [3:0] i, output logic [31:0] a, output logic [31:0] b);
		@(negedge clk_i);
		{ra_o, rb_o} <= {i, i};
		@(negedge clk_i);
		a = rd_a_i;
		b = rd_b_i;
	endtask
endmodule

// file: sim/brf_regfile_tb.sv
/*
 Self-checking bench for the banked register file.
 Assumes the exec model drives requests and the checker is bound in.
*/
`timescale 1ns/1ps
module brf_regfile_tb;
	logic                clk_i;
	logic                reset_n_i;
	brf_pkg::brf_wr_t    wr;
	brf_pkg::brf_flags_t flg;
	brf_pkg::brf_flags_t flo;
	logic [3:0]          ra, rb;
	logic                call, pld, fwe, swe, ssel, exc, efd, prv, mv;
	logic [4:0]          emode, mode;
	logic [31:0]         arg, evec, rda, rdb, pc, cur_sw, sav_sw, es;
	logic [4:0]          ml [7] = '{5'h11, 5'h12, 5'h13, 5'h17, 5'h1B, 5'h1F, 5'h10};
	int                  errors, checked, cyc;

	brf_regfile dut_u
	(
		.clk_i(clk_i), .reset_n_i(reset_n_i), .rd_a_idx_i(ra), .rd_b_idx_i(rb), .wr_i(wr),
		.call_branch_i(call), .call_return_i(arg), .pc_load_i(pld), .pc_value_i(arg),
		.flags_we_i(fwe), .flags_i(flg), .status_we_i(swe), .status_saved_sel_i(ssel),
		.status_data_i(arg), .exc_i(exc), .exc_mode_i(emode), .exc_fiq_dis_i(efd),
		.exc_return_i(arg), .exc_vector_i(evec), .rd_a_data_o(rda), .rd_b_data_o(rdb),
		.pc_o(pc), .current_status_word_o(cur_sw), .saved_status_word_o(sav_sw), .flags_o(flo),
		.mode_o(mode), .privileged_o(prv), .mode_valid_o(mv)
	);
	brf_exec_model px
	(
		.clk_i(clk_i), .rd_a_i(rda), .rd_b_i(rdb), .wr_o(wr), .ra_o(ra), .rb_o(rb), .call_o(call),
		.pld_o(pld), .fwe_o(fwe), .flg_o(flg), .swe_o(swe), .ssel_o(ssel), .arg_o(arg), .exc_o(exc),
		.emode_o(emode), .efd_o(efd), .evec_o(evec)
	);

	function automatic logic [31:0] pat(input int k);
		return 32'h9E3779B9 * k + 32'h1;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic rdc(input logic [3:0] i, input logic [31:0] e);
		logic [31:0] a, b;
		px.rd(i, a, b);
		chk(a, e);
		chk(b, e);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			errors++;
			print_verdict();
		end
	end

	initial
	begin
		reset_n_i = 1'b0;
		repeat (5) @(posedge clk_i);
		@(negedge clk_i);
		reset_n_i = 1'b1;
		chk(cur_sw, 32'h000000D3);
		chk(sav_sw, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 15; i++)
			px.wr(i[3:0], pat(i));
		for (int i = 0; i < 15; i++)
			rdc(i[3:0], pat(i));
		$display("test general done");
		for (int k = 0; k < 7; k++)
		begin
			px.sts(1'b0, {24'h0, 3'b110, ml[k]});
			chk({27'h0, mode}, {27'h0, ml[k]});
			chk({30'h0, mv, prv}, {30'h0, 1'b1, ml[k] != 5'h10});
			if (k < 6)
			begin
				px.wr(4'hD, pat(k + 32));
				px.wr(4'hE, pat(k + 48));
			end
			for (int i = 8; i < 13 && k == 0; i++)
				px.wr(i[3:0], pat(i + 64));
		end
		for (int i = 8; i < 15; i++)
			rdc(i[3:0], pat(i < 13 ? i : i * 16 - 171));
		$display("test banking done");
		px.sts(1'b0, 32'h000000D3);
		px.sts(1'b1, 32'hFFFFFFFF);
		px.flg(4'hA);
		chk(cur_sw, 32'hA00000D0);
		chk({28'h0, flo}, 32'hA);
		chk(sav_sw, 32'h0);
		$display("test user done");
		es = 32'hA00000D0;
		for (int k = 0; k < 5; k++)
		begin
			px.exc(ml[k], k == 0, pat(k + 96), 32'h00000100 + k * 4);
			chk(sav_sw, es);
			es = {27'h5000006, ml[k]};
			chk(cur_sw, es);
			rdc(4'hD, pat(k + 32));
			rdc(4'hE, pat(k + 96));
			if (k == 0)
				rdc(4'h8, pat(72));
		end
		$display("test exception done");
		px.wr(4'hF, 32'h00001237);
		chk(pc, 32'h00001234);
		rdc(4'hF, 32'h00001240);
		px.pcld(32'h00002003);
		chk(pc, 32'h00002000);
		px.call(32'h00003000);
		rdc(4'hE, 32'h00003000);
		px.sts(1'b0, 32'h000000C5);
		chk({31'h0, mv}, 32'h0);
		chk({31'h0, prv}, 32'h0);
		rdc(4'hD, pat(37));
		chk(sav_sw, 32'h0);
		px.sts(1'b0, 32'h00000013);
		chk(cur_sw, 32'h000000C5);
		$display("test counter done");
		print_verdict();
	end
endmodule
